/* File: shared/rss_regs.svh */
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH
// Contract
// - output command register 0x0000, 1 on, reset 0
// - command acts only in link or combined source
// - source select 0x000A: terminal, link, both
// - unselected on/off sources are ignored
// - source 2 turns on on terminal AND command
// - persistence register 0x000B: volatile or non-volatile
// - volatile: command starts off at every power-up
// - non-volatile: command reloads last stored value
// - debounce register 0x000C, 0 to 100 ms, reset 10
// - larger debounce filters terminal longer before accepting
// - polarity register 0x000D inverts terminal sense
// - voltage source 0x0064: auto, terminal, link
// - auto voltage: pot until terminal once reaches 1V
// - current source 0x0065: auto, terminal, link
// - auto current: limit until terminal once reaches 1V
// - link voltage target 0 to model maximum, reset 0
// - voltage equals target over 4000 times rated
`define RSS_A_CMD    16'h0000
`define RSS_A_SRC    16'h000A
`define RSS_A_PERS   16'h000B
`define RSS_A_DEB    16'h000C
`define RSS_A_POL    16'h000D
`define RSS_A_CVS    16'h0064
`define RSS_A_CCS    16'h0065
`define RSS_A_CVT    16'h006E
`define RSS_MAX_BIT  16'h0001
`define RSS_MAX_SEL  16'h0002
`define RSS_MAX_DEB  16'h0064
`define RSS_RST_DEB  7'h0A
`define RSS_SEL_TERM 2'h0
`define RSS_SEL_LINK 2'h1
`define RSS_SEL_BOTH 2'h2
`define RSS_CV_FULL  32'h00000FA0
`define RSS_CV_MAX_A 16'h1158
`define RSS_CV_MAX_B 16'h12E8
`define RSS_MS_NS    32'h000F4240
`define RSS_CLK_NS   32'h00000005
`define RSS_TICK_CYC (`RSS_MS_NS / `RSS_CLK_NS)
`endif

/* File: shared/rss_pkg.sv */
package rss_pkg;
  typedef enum logic [1:0] {RSS_SRC_LOCAL, RSS_SRC_TERM, RSS_SRC_LINK} rss_src_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rss_req_t;
  typedef struct packed {
    logic        ack;
    logic        exc;
    logic [15:0] rdata;
  } rss_rsp_t;
  typedef struct packed {
    logic term_on;
    logic cv_hi;
    logic cc_hi;
  } rss_pins_t;
  typedef struct packed {
    rss_pins_t s1;
    rss_pins_t s2;
    rss_pins_t s3;
    rss_pins_t q;
  } rss_sync_st_t;
  typedef struct packed {
    logic [31:0] tick;
    logic [6:0]  ms;
    logic        level;
  } rss_deb_st_t;
  typedef struct packed {
    logic        boot;
    logic        cmd;
    logic [1:0]  src;
    logic        pers;
    logic [6:0]  deb;
    logic        pol;
    logic [1:0]  cvs;
    logic [1:0]  ccs;
    logic [15:0] cvt;
    logic        cv_lat;
    logic        cc_lat;
    logic        oe;
    rss_src_t    cv_src;
    rss_src_t    cc_src;
    logic [15:0] cv_out;
    rss_rsp_t    rsp;
  } rss_top_st_t;
endpackage : rss_pkg

/* File: design/rss_sync3.sv */
`timescale 1ns/1ps
module rss_sync3 (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              clk_en_i,
  // pins in, settled out
  input  wire rss_pkg::rss_pins_t pins_i,
  output rss_pkg::rss_pins_t      pins_o
);
  rss_pkg::rss_sync_st_t state_reg;
  rss_pkg::rss_sync_st_t state_next;

  // s1 feeds only s2; q moves only once s2 and s3 agree per pin
  always_comb begin
    state_next    = state_reg;
    state_next.s1 = pins_i;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    if (state_reg.s2.term_on == state_reg.s3.term_on) state_next.q.term_on = state_reg.s3.term_on;
    if (state_reg.s2.cv_hi == state_reg.s3.cv_hi) state_next.q.cv_hi = state_reg.s3.cv_hi;
    if (state_reg.s2.cc_hi == state_reg.s3.cc_hi) state_next.q.cc_hi = state_reg.s3.cc_hi;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  assign pins_o = state_reg.q;
endmodule : rss_sync3

/* File: design/rss_debounce.sv */
`timescale 1ns/1ps
`include "rss_regs.svh"
module rss_debounce #(
  parameter int unsigned TICK_CYC = `RSS_TICK_CYC
) (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clk_en_i,
  // level and filter length
  input  wire logic       din_i,
  input  wire logic [6:0] limit_i,
  output logic            level_o
);
  rss_pkg::rss_deb_st_t state_reg;
  rss_pkg::rss_deb_st_t state_next;
  logic                 tick;

  always_comb begin
    state_next      = state_reg;
    tick            = (state_reg.tick == 32'(TICK_CYC - 1));
    state_next.tick = tick ? '0 : state_reg.tick + 32'h00000001;
    if (din_i == state_reg.level) begin
      state_next.ms = '0; // any bounce back restarts the wait
    end else if (limit_i == 7'h00) begin
      state_next.level = din_i;
    end else if (tick) begin
      if (state_reg.ms + 7'h01 >= limit_i) begin
        state_next.level = din_i;
        state_next.ms    = '0;
      end else begin
        state_next.ms = state_reg.ms + 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  assign level_o = state_reg.level;

  deb_on_tick_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && (state_next.level != state_reg.level) |-> tick || (limit_i == 7'h00))
    else $error("debounce level moved off a tick");

  bounce_restart_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && (din_i == state_reg.level) |=> state_reg.ms == 7'h00)
    else $error("bounce did not restart the wait");
endmodule : rss_debounce

/* File: design/rss_top.sv */
`timescale 1ns/1ps
`include "rss_regs.svh"
module rss_top #(
  parameter logic [15:0] CV_MAX   = `RSS_CV_MAX_A,
  parameter logic [15:0] RATED_CV = 16'h0960,
  parameter int unsigned TICK_CYC = `RSS_TICK_CYC
) (
  // clock, reset, freeze
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               clk_en_i,
  // register requests and answers
  input  wire rss_pkg::rss_req_t  req_i,
  output rss_pkg::rss_rsp_t       rsp_o,
  // terminal pins
  input  wire logic               term_on_i,
  input  wire logic               cv_term_hi_i,
  input  wire logic               cc_term_hi_i,
  // non-volatile store
  input  wire logic               nv_persist_i,
  input  wire logic               nv_cmd_i,
  output logic                    nv_persist_o,
  output logic                    nv_cmd_o,
  // output control
  output logic                    output_enable_o,
  output rss_pkg::rss_src_t       cv_src_o,
  output rss_pkg::rss_src_t       cc_src_o,
  output logic [15:0]             cv_target_o
);
  rss_pkg::rss_top_st_t state_reg;
  rss_pkg::rss_top_st_t state_next;
  rss_pkg::rss_pins_t   pins_raw;
  rss_pkg::rss_pins_t   pins_sync;
  logic                 term_deb;
  logic                 term_lvl;
  logic                 take;
  logic [31:0]          cv_prod;
  logic [31:0]          cv_scaled;

  assign pins_raw.term_on = term_on_i;
  assign pins_raw.cv_hi   = cv_term_hi_i;
  assign pins_raw.cc_hi   = cc_term_hi_i;

  rss_sync3 u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .clk_en_i   (clk_en_i),
    .pins_i     (pins_raw),
    .pins_o     (pins_sync)
  );

  rss_debounce #(
    .TICK_CYC (TICK_CYC)
  ) u_deb (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .clk_en_i   (clk_en_i),
    .din_i      (pins_sync.term_on),
    .limit_i    (state_reg.deb),
    .level_o    (term_deb)
  );

  // write check: mapped and inside min..max
  function automatic logic wr_ok(input logic [15:0] addr, input logic [15:0] data,
                                 input logic [15:0] cv_max);
    case (addr)
      `RSS_A_CMD:  wr_ok = (data <= `RSS_MAX_BIT);
      `RSS_A_SRC:  wr_ok = (data <= `RSS_MAX_SEL);
      `RSS_A_PERS: wr_ok = (data <= `RSS_MAX_BIT);
      `RSS_A_DEB:  wr_ok = (data <= `RSS_MAX_DEB);
      `RSS_A_POL:  wr_ok = (data <= `RSS_MAX_BIT);
      `RSS_A_CVS:  wr_ok = (data <= `RSS_MAX_SEL);
      `RSS_A_CCS:  wr_ok = (data <= `RSS_MAX_SEL);
      `RSS_A_CVT:  wr_ok = (data <= cv_max);
      default:     wr_ok = 1'b0;
    endcase
  endfunction : wr_ok

  // three-way selector decode shared by both target sources
  function automatic rss_pkg::rss_src_t pick(input logic [1:0] sel, input logic lat);
    case (sel)
      `RSS_SEL_TERM: pick = lat ? rss_pkg::RSS_SRC_TERM : rss_pkg::RSS_SRC_LOCAL;
      `RSS_SEL_LINK: pick = rss_pkg::RSS_SRC_TERM;
      default:       pick = rss_pkg::RSS_SRC_LINK;
    endcase
  endfunction : pick

  assign term_lvl  = term_deb ^ state_reg.pol;
  assign take      = state_reg.boot && (req_i.wr || req_i.rd);
  // full-scale 4000 maps to the rated voltage, RATED_CV in 10 mV steps
  assign cv_prod   = {16'h0000, state_reg.cvt} * {16'h0000, RATED_CV};
  assign cv_scaled = cv_prod / `RSS_CV_FULL;

  always_comb begin
    state_next           = state_reg;
    state_next.rsp.ack   = 1'b0;
    state_next.rsp.exc   = 1'b0;
    state_next.rsp.rdata = '0;

    // power-up load; store is read once, after release, never under reset
    if (!state_reg.boot) begin
      state_next.boot = 1'b1;
      state_next.pers = nv_persist_i;
      state_next.cmd  = nv_persist_i & nv_cmd_i;
    end

    if (take && req_i.wr) begin
      state_next.rsp.ack = 1'b1;
      if (!wr_ok(req_i.addr, req_i.wdata, CV_MAX)) begin
        state_next.rsp.exc = 1'b1; // stored value kept
      end else begin
        case (req_i.addr)
          `RSS_A_CMD:  state_next.cmd  = req_i.wdata[0];
          `RSS_A_SRC:  state_next.src  = req_i.wdata[1:0];
          `RSS_A_PERS: state_next.pers = req_i.wdata[0];
          `RSS_A_DEB:  state_next.deb  = req_i.wdata[6:0];
          `RSS_A_POL:  state_next.pol  = req_i.wdata[0];
          `RSS_A_CVS:  state_next.cvs  = req_i.wdata[1:0];
          `RSS_A_CCS:  state_next.ccs  = req_i.wdata[1:0];
          `RSS_A_CVT:  state_next.cvt  = req_i.wdata;
          default:     state_next.rsp.exc = 1'b1;
        endcase
      end
    end else if (take) begin
      state_next.rsp.ack = 1'b1;
      case (req_i.addr)
        `RSS_A_CMD:  state_next.rsp.rdata = {15'h0000, state_reg.cmd};
        `RSS_A_SRC:  state_next.rsp.rdata = {14'h0000, state_reg.src};
        `RSS_A_PERS: state_next.rsp.rdata = {15'h0000, state_reg.pers};
        `RSS_A_DEB:  state_next.rsp.rdata = {9'h000, state_reg.deb};
        `RSS_A_POL:  state_next.rsp.rdata = {15'h0000, state_reg.pol};
        `RSS_A_CVS:  state_next.rsp.rdata = {14'h0000, state_reg.cvs};
        `RSS_A_CCS:  state_next.rsp.rdata = {14'h0000, state_reg.ccs};
        `RSS_A_CVT:  state_next.rsp.rdata = state_reg.cvt;
        default:     state_next.rsp.exc   = 1'b1;
      endcase
    end

    // unselected sources never reach the enable
    case (state_reg.src)
      `RSS_SEL_TERM: state_next.oe = term_lvl;
      `RSS_SEL_LINK: state_next.oe = state_reg.cmd;
      `RSS_SEL_BOTH: state_next.oe = term_lvl & state_reg.cmd;
      default:       state_next.oe = 1'b0;
    endcase

    // latches clear only on power loss, i.e. reset
    if (pins_sync.cv_hi) state_next.cv_lat = 1'b1;
    if (pins_sync.cc_hi) state_next.cc_lat = 1'b1;
    state_next.cv_src = pick(state_reg.cvs, state_reg.cv_lat);
    state_next.cc_src = pick(state_reg.ccs, state_reg.cc_lat);
    state_next.cv_out = cv_scaled[15:0];
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg     <= '0;
      state_reg.deb <= `RSS_RST_DEB;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  assign rsp_o           = state_reg.rsp;
  assign nv_persist_o    = state_reg.pers;
  assign nv_cmd_o        = state_reg.cmd;
  assign output_enable_o = state_reg.oe;
  assign cv_src_o        = state_reg.cv_src;
  assign cc_src_o        = state_reg.cc_src;
  assign cv_target_o     = state_reg.cv_out;

  cmd_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && take && req_i.wr && req_i.addr == `RSS_A_CMD && req_i.wdata <= `RSS_MAX_BIT
    |=> nv_cmd_o == $past(req_i.wdata[0]) && rsp_o.ack && !rsp_o.exc)
    else $error("command write not stored");

  src_term_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && state_reg.boot && state_reg.src == `RSS_SEL_TERM |=> output_enable_o == $past(term_lvl))
    else $error("terminal source not followed");

  src_link_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && state_reg.src == `RSS_SEL_LINK && state_reg.boot |=> output_enable_o == $past(state_reg.cmd))
    else $error("link source not followed");

  src_both_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && state_reg.src == `RSS_SEL_BOTH |=> output_enable_o == $past(term_lvl & state_reg.cmd))
    else $error("combined source is not an and");

  boot_vol_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(state_reg.boot) && !$past(nv_persist_i) |-> !nv_cmd_o && !nv_persist_o)
    else $error("volatile start not off");

  boot_nv_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(state_reg.boot) && $past(nv_persist_i) |-> nv_cmd_o == $past(nv_cmd_i) && nv_persist_o)
    else $error("stored command not restored");

  bad_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && take && req_i.wr && req_i.addr == `RSS_A_DEB && req_i.wdata > `RSS_MAX_DEB
    |=> rsp_o.exc && state_reg.deb == $past(state_reg.deb))
    else $error("out of range write accepted");

  cv_auto_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && state_reg.cv_lat && state_reg.cvs == `RSS_SEL_TERM
    |=> state_reg.cv_lat && cv_src_o == rss_pkg::RSS_SRC_TERM)
    else $error("voltage auto latch lost");

  cc_auto_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && !state_reg.cc_lat && !pins_sync.cc_hi && state_reg.ccs == `RSS_SEL_TERM
    |=> cc_src_o == rss_pkg::RSS_SRC_LOCAL)
    else $error("current auto left limit early");

  cvt_range_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg.cvt <= CV_MAX)
    else $error("voltage target above maximum");

  cv_link_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && state_reg.cvs == `RSS_SEL_BOTH |=> cv_src_o == rss_pkg::RSS_SRC_LINK)
    else $error("link voltage source not chosen");

  cv_term_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && state_reg.cvs == `RSS_SEL_LINK |=> cv_src_o == rss_pkg::RSS_SRC_TERM)
    else $error("terminal voltage source not chosen");

  cc_link_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && state_reg.ccs == `RSS_SEL_BOTH |=> cc_src_o == rss_pkg::RSS_SRC_LINK)
    else $error("link current source not chosen");

  src_range_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg.src <= `RSS_SEL_BOTH)
    else $error("source select out of range");

  deb_range_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    {9'h000, state_reg.deb} <= `RSS_MAX_DEB)
    else $error("debounce setting out of range");

  deb_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && take && !req_i.wr && req_i.addr == `RSS_A_DEB
    |=> rsp_o.ack && !rsp_o.exc && rsp_o.rdata == {9'h000, $past(state_reg.deb)})
    else $error("debounce read wrong");

  cvt_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && take && req_i.wr && req_i.addr == `RSS_A_CVT && req_i.wdata > CV_MAX
    |=> rsp_o.exc && state_reg.cvt == $past(state_reg.cvt))
    else $error("voltage target overwritten");
endmodule : rss_top

/* File: verification/rss_client.sv */
`timescale 1ns/1ps
module rss_client (
  // clock
  input  wire logic              core_clk_i,
  // requests out, answers in
  output rss_pkg::rss_req_t      req_o,
  input  wire rss_pkg::rss_rsp_t rsp_i
);
  initial req_o = '0;

  // one word per request; released lines carry the inverse so stale values never pass
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic e, output logic k);
    @(posedge core_clk_i);
    req_o <= '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge core_clk_i);
    // one-cycle strobe: held longer it would be taken again
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(posedge core_clk_i);
    k = rsp_i.ack;
    e = rsp_i.exc;
    q = rsp_i.rdata;
  endtask : xfer
endmodule : rss_client

/* File: verification/tb.sv */
`timescale 1ns/1ps
`include "rss_regs.svh"
module tb;
  localparam logic [15:0] CV_MAX = 16'h1158;
  localparam logic [15:0] RATED  = 16'h0960;
  logic              core_clk_i, rst_n_i, term_on_i, cv_hi, cc_hi, nv_p, nv_c;
  logic              nv_p_o, nv_c_o, oe, clk_en;
  logic [15:0]       cv_tgt;
  rss_pkg::rss_req_t req;
  rss_pkg::rss_rsp_t rsp;
  rss_pkg::rss_src_t cv_src, cc_src;
  int                error_cnt = 0;
  int                cmp_count = 0;
  int                cyc = 0;

  rss_top #(.CV_MAX(CV_MAX), .RATED_CV(RATED), .TICK_CYC(10)) dut_u (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en), .req_i(req), .rsp_o(rsp),
    .term_on_i(term_on_i), .cv_term_hi_i(cv_hi), .cc_term_hi_i(cc_hi), .nv_persist_i(nv_p),
    .nv_cmd_i(nv_c), .nv_persist_o(nv_p_o), .nv_cmd_o(nv_c_o), .output_enable_o(oe),
    .cv_src_o(cv_src), .cc_src_o(cc_src), .cv_target_o(cv_tgt));

  rss_client client_u (.core_clk_i(core_clk_i), .req_o(req), .rsp_i(rsp));

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // guard against a hung handshake
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic ex);
    logic [15:0] q;
    logic        e, k;
    client_u.xfer(1'b1, a, d, q, e, k);
    chk({k, e}, {1'b1, ex});
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic ex);
    logic [15:0] q;
    logic        e, k;
    client_u.xfer(1'b0, a, 16'h0000, q, e, k);
    chk({k, e}, {1'b1, ex});
    if (!ex) chk(q, exp);
  endtask : rd

  // sync plus zero-length filter plus output flop fit well inside this
  task automatic settle();
    repeat (10) @(posedge core_clk_i);
  endtask : settle

  task automatic term(input logic v);
    @(posedge core_clk_i);
    term_on_i <= v;
    settle();
  endtask : term

  task automatic do_reset(input logic p, input logic c);
    @(posedge core_clk_i);
    nv_p <= p;
    nv_c <= c;
    rst_n_i <= 1'b0;
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
  endtask : do_reset

  task automatic t_reset_vals();
    rd(`RSS_A_CMD, 16'h0000, 1'b0);
    rd(`RSS_A_SRC, 16'h0000, 1'b0);
    rd(`RSS_A_PERS, 16'h0000, 1'b0);
    rd(`RSS_A_DEB, 16'h000A, 1'b0);
    rd(`RSS_A_POL, 16'h0000, 1'b0);
    rd(`RSS_A_CVS, 16'h0000, 1'b0);
    rd(`RSS_A_CCS, 16'h0000, 1'b0);
    rd(`RSS_A_CVT, 16'h0000, 1'b0);
    rd(16'h0001, 16'h0000, 1'b1);
    chk(oe, 16'h0000);
  endtask : t_reset_vals

  task automatic t_range();
    wr(`RSS_A_SRC, 16'h0003, 1'b1);
    rd(`RSS_A_SRC, 16'h0000, 1'b0);
    wr(`RSS_A_DEB, 16'h0065, 1'b1);
    wr(`RSS_A_DEB, 16'h0064, 1'b0);
    rd(`RSS_A_DEB, 16'h0064, 1'b0);
    wr(`RSS_A_CVT, CV_MAX + 16'h0001, 1'b1);
    wr(`RSS_A_CVT, CV_MAX, 1'b0);
    rd(`RSS_A_CVT, CV_MAX, 1'b0);
    wr(`RSS_A_CMD, 16'h0002, 1'b1);
    wr(`RSS_A_PERS, 16'h0002, 1'b1);
    wr(`RSS_A_POL, 16'h0002, 1'b1);
    wr(`RSS_A_CCS, 16'h0003, 1'b1);
    wr(16'h006F, 16'h0000, 1'b1);
  endtask : t_range

  task automatic t_enable();
    wr(`RSS_A_DEB, 16'h0000, 1'b0);
    term(1'b1);
    chk(oe, 16'h0001);
    wr(`RSS_A_POL, 16'h0001, 1'b0);
    settle();
    chk(oe, 16'h0000);
    wr(`RSS_A_POL, 16'h0000, 1'b0);
    wr(`RSS_A_SRC, 16'h0001, 1'b0);
    settle();
    chk(oe, 16'h0000);
    wr(`RSS_A_CMD, 16'h0001, 1'b0);
    term(1'b0);
    chk(oe, 16'h0001);
    wr(`RSS_A_SRC, 16'h0002, 1'b0);
    settle();
    chk(oe, 16'h0000);
    term(1'b1);
    chk(oe, 16'h0001);
    wr(`RSS_A_CMD, 16'h0000, 1'b0);
    settle();
    chk(oe, 16'h0000);
    wr(`RSS_A_SRC, 16'h0000, 1'b0);
    settle();
    chk(oe, 16'h0001);
  endtask : t_enable

  // frozen clock enable: request ignored, register kept
  task automatic t_freeze();
    logic [15:0] q;
    logic        e, k;
    @(posedge core_clk_i);
    clk_en <= 1'b0;
    client_u.xfer(1'b1, `RSS_A_CMD, 16'h0001, q, e, k);
    chk({k, e}, 16'h0000);
    @(posedge core_clk_i);
    clk_en <= 1'b1;
    rd(`RSS_A_CMD, 16'h0000, 1'b0);
  endtask : t_freeze

  task automatic t_debounce();
    wr(`RSS_A_DEB, 16'h0003, 1'b0);
    @(posedge core_clk_i);
    term_on_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    term_on_i <= 1'b1;
    repeat (60) @(posedge core_clk_i);
    chk(oe, 16'h0001);
    term_on_i <= 1'b0;
    repeat (15) @(posedge core_clk_i);
    chk(oe, 16'h0001);
    repeat (45) @(posedge core_clk_i);
    chk(oe, 16'h0000);
  endtask : t_debounce

  task automatic t_sources();
    chk(cv_src, rss_pkg::RSS_SRC_LOCAL);
    chk(cc_src, rss_pkg::RSS_SRC_LOCAL);
    @(posedge core_clk_i);
    cv_hi <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    cv_hi <= 1'b0;
    settle();
    chk(cv_src, rss_pkg::RSS_SRC_TERM);
    chk(cc_src, rss_pkg::RSS_SRC_LOCAL);
    cc_hi <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    cc_hi <= 1'b0;
    settle();
    chk(cc_src, rss_pkg::RSS_SRC_TERM);
    wr(`RSS_A_CVS, 16'h0002, 1'b0);
    wr(`RSS_A_CVT, 16'h0FA0, 1'b0);
    settle();
    chk(cv_src, rss_pkg::RSS_SRC_LINK);
    chk(cv_tgt, RATED);
    wr(`RSS_A_CVT, 16'h07D0, 1'b0);
    settle();
    chk(cv_tgt, 16'h04B0);
    wr(`RSS_A_CVS, 16'h0001, 1'b0);
    wr(`RSS_A_CCS, 16'h0002, 1'b0);
    settle();
    chk(cv_src, rss_pkg::RSS_SRC_TERM);
    chk(cc_src, rss_pkg::RSS_SRC_LINK);
  endtask : t_sources

  task automatic t_persist();
    wr(`RSS_A_CMD, 16'h0001, 1'b0);
    wr(`RSS_A_PERS, 16'h0001, 1'b0);
    @(posedge core_clk_i);
    chk({nv_p_o, nv_c_o}, 16'h0003);
    do_reset(1'b0, 1'b1);
    rd(`RSS_A_CMD, 16'h0000, 1'b0);
    rd(`RSS_A_PERS, 16'h0000, 1'b0);
    do_reset(1'b1, 1'b1);
    rd(`RSS_A_CMD, 16'h0001, 1'b0);
    rd(`RSS_A_PERS, 16'h0001, 1'b0);
    chk(cv_src, rss_pkg::RSS_SRC_LOCAL);
  endtask : t_persist

  initial begin
    rst_n_i = 1'b0;
    clk_en = 1'b1;
    term_on_i = 1'b0;
    cv_hi = 1'b0;
    cc_hi = 1'b0;
    nv_p = 1'b0;
    nv_c = 1'b0;
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    t_reset_vals();
    t_range();
    t_enable();
    t_freeze();
    t_debounce();
    t_sources();
    t_persist();
    report_and_stop();
  end
endmodule : tb
